// ### logic/tdm_pkg.sv
// constants shared by the timeslot drop and insert multiplexer
package tdm_pkg;
	localparam int unsigned TDM_SLOT_W = 5;
	localparam logic [4:0] TDM_E1_LAST = 5'h1f;
	localparam logic [4:0] TDM_T1_LAST = 5'h17;
	localparam logic [4:0] TDM_E1_FIRST_SEL = 5'h01;
	localparam logic [4:0] TDM_T1_NUM_OFS = 5'h01;
	localparam logic [4:0] TDM_T1E1_LAST_SEL = 5'h19;
	localparam logic [4:0] TDM_SLOT_ZERO = 5'h00;
	localparam logic [7:0] TDM_IDLE_E1 = 8'h55;
	localparam logic [7:0] TDM_IDLE_T1 = 8'h7f;
	localparam logic [7:0] TDM_BYTE_ZERO = 8'h00;
endpackage

// ### logic/tdm_mux.sv
// timeslot drop and insert multiplexer for t1 and e1 bearers
`timescale 1ns/1ns
module tdm_mux
	import tdm_pkg::*;
(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic e1_mode_i,
	input wire logic t1_in_e1_i,
	input wire logic idle_fill_i,
	input wire logic twin_mode_i,
	input wire logic [31:0] drop_sel_i,
	input wire logic [31:0] ins_sel_i,
	input wire logic [7:0] send_data_port_i,
	input wire logic send_valid_i,
	input wire logic send_fsync_i,
	output logic [7:0] dropped_data_out_port_o,
	output logic dropped_valid_o,
	output logic dropped_fsync_o,
	output logic [7:0] agg_tx_data_o,
	output logic agg_tx_valid_o,
	input wire logic [7:0] insert_data_in_port_i,
	input wire logic insert_valid_i,
	input wire logic insert_fsync_i,
	input wire logic [7:0] agg_rx_data_i,
	output logic agg_rx_take_o,
	output logic [7:0] receive_data_o,
	output logic receive_valid_o,
	output logic receive_fsync_o
);

	// ****************************************************************
	// slot helpers
	// ****************************************************************
	function automatic logic [4:0] slot_cur(input logic fsync, input logic [4:0] cnt);
		slot_cur = fsync ? TDM_SLOT_ZERO : cnt;
	endfunction

	function automatic logic [4:0] slot_next(input logic [4:0] cur, input logic e1);
		logic [4:0] last;
		last = e1 ? TDM_E1_LAST : TDM_T1_LAST;
		slot_next = (cur == last) ? TDM_SLOT_ZERO : 5'(cur + 5'h01);
	endfunction

	// byte index within the frame to slot number, then check against the mask unless a t1 is carried in e1
	function automatic logic slot_sel(input logic [31:0] mask, input logic [4:0] idx,
		input logic e1, input logic t1e1);
		logic [4:0] num;
		logic ok;
		num = e1 ? idx : 5'(idx + TDM_T1_NUM_OFS);
		ok = e1 ? (num >= TDM_E1_FIRST_SEL) : (idx <= TDM_T1_LAST);
		if (e1 && t1e1) begin
			// a carried t1 takes slots 1 to 25 whole, timeslot 16 among them
			slot_sel = (num >= TDM_E1_FIRST_SEL) && (num <= TDM_T1E1_LAST_SEL);
		end else begin
			slot_sel = ok && mask[num];
		end
	endfunction

	// ****************************************************************
	// drop side
	// ****************************************************************
	logic [4:0] drop_cnt_q, drop_cnt_d, drop_idx;
	logic drop_hit;
	logic [7:0] ddo_q, ddo_d, agg_q, agg_d;
	logic ddo_v_q, ddo_v_d, ddo_f_q, ddo_f_d, agg_v_q, agg_v_d;

	assign drop_idx = slot_cur(send_fsync_i, drop_cnt_q);
	assign drop_hit = send_valid_i && slot_sel(drop_sel_i, drop_idx, e1_mode_i, t1_in_e1_i);

	always_comb begin
		drop_cnt_d = drop_cnt_q;
		ddo_d = ddo_q;
		ddo_v_d = send_valid_i;
		ddo_f_d = send_valid_i && send_fsync_i;
		agg_d = agg_q;
		agg_v_d = drop_hit;
		if (send_valid_i) begin
			drop_cnt_d = slot_next(drop_idx, e1_mode_i);
			ddo_d = send_data_port_i;
			if (drop_hit) begin
				agg_d = send_data_port_i;
				if (idle_fill_i) begin
					ddo_d = e1_mode_i ? TDM_IDLE_E1 : TDM_IDLE_T1;
				end
			end
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			drop_cnt_q <= TDM_SLOT_ZERO;
			ddo_q <= TDM_BYTE_ZERO;
			ddo_v_q <= 1'b0;
			ddo_f_q <= 1'b0;
			agg_q <= TDM_BYTE_ZERO;
			agg_v_q <= 1'b0;
		end else begin
			drop_cnt_q <= drop_cnt_d;
			ddo_q <= ddo_d;
			ddo_v_q <= ddo_v_d;
			ddo_f_q <= ddo_f_d;
			agg_q <= agg_d;
			agg_v_q <= agg_v_d;
		end
	end

	assign dropped_data_out_port_o = ddo_q;
	assign dropped_valid_o = ddo_v_q;
	assign dropped_fsync_o = ddo_f_q;
	assign agg_tx_data_o = agg_q;
	assign agg_tx_valid_o = agg_v_q;

	// ****************************************************************
	// insert side
	// ****************************************************************
	// single bearer reuses the dropped bearer one cycle late; twin takes its own
	logic [7:0] ins_byte;
	logic ins_valid, ins_fsync, ins_hit;
	logic [4:0] ins_cnt_q, ins_cnt_d, ins_idx;
	logic [7:0] rd_q, rd_d;
	logic rd_v_q, rd_v_d, rd_f_q, rd_f_d, take_q, take_d;

	assign ins_byte = twin_mode_i ? insert_data_in_port_i : ddo_q;
	assign ins_valid = twin_mode_i ? insert_valid_i : ddo_v_q;
	assign ins_fsync = twin_mode_i ? insert_fsync_i : ddo_f_q;
	assign ins_idx = slot_cur(ins_fsync, ins_cnt_q);
	assign ins_hit = ins_valid && slot_sel(ins_sel_i, ins_idx, e1_mode_i, t1_in_e1_i);

	always_comb begin
		ins_cnt_d = ins_cnt_q;
		rd_d = rd_q;
		rd_v_d = ins_valid;
		rd_f_d = ins_valid && ins_fsync;
		// one aggregate byte per selected slot, taken in arrival order
		take_d = ins_hit;
		if (ins_valid) begin
			ins_cnt_d = slot_next(ins_idx, e1_mode_i);
			rd_d = ins_hit ? agg_rx_data_i : ins_byte;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ins_cnt_q <= TDM_SLOT_ZERO;
			rd_q <= TDM_BYTE_ZERO;
			rd_v_q <= 1'b0;
			rd_f_q <= 1'b0;
			take_q <= 1'b0;
		end else begin
			ins_cnt_q <= ins_cnt_d;
			rd_q <= rd_d;
			rd_v_q <= rd_v_d;
			rd_f_q <= rd_f_d;
			take_q <= take_d;
		end
	end

	assign receive_data_o = rd_q;
	assign receive_valid_o = rd_v_q;
	assign receive_fsync_o = rd_f_q;
	assign agg_rx_take_o = take_q;

	// ****************************************************************
	// checks
	// ****************************************************************
	property p_drop_agg;
		@(posedge clk_i) disable iff (!rstn_i)
		drop_hit |=> agg_v_q && (agg_q == $past(send_data_port_i));
	endproperty
	a_drop_agg: assert property (p_drop_agg) else $error("dropped byte not on aggregate");

	property p_idle_e1;
		@(posedge clk_i) disable iff (!rstn_i)
		drop_hit && idle_fill_i && e1_mode_i |=> ddo_q == TDM_IDLE_E1;
	endproperty
	a_idle_e1: assert property (p_idle_e1) else $error("e1 idle code missing");

	property p_idle_t1;
		@(posedge clk_i) disable iff (!rstn_i)
		drop_hit && idle_fill_i && !e1_mode_i |=> ddo_q == TDM_IDLE_T1;
	endproperty
	a_idle_t1: assert property (p_idle_t1) else $error("t1 idle code missing");

	property p_pass;
		@(posedge clk_i) disable iff (!rstn_i)
		send_valid_i && !(drop_hit && idle_fill_i) |=> ddo_q == $past(send_data_port_i);
	endproperty
	a_pass: assert property (p_pass) else $error("bearer byte altered");

	property p_no_agg;
		@(posedge clk_i) disable iff (!rstn_i)
		!drop_hit |=> !agg_v_q;
	endproperty
	a_no_agg: assert property (p_no_agg) else $error("spurious aggregate byte");

	property p_e1_slot0;
		@(posedge clk_i) disable iff (!rstn_i)
		send_valid_i && send_fsync_i && e1_mode_i |=> !agg_v_q ##0 ddo_f_q;
	endproperty
	a_e1_slot0: assert property (p_e1_slot0) else $error("e1 slot zero dropped");

	property p_align;
		@(posedge clk_i) disable iff (!rstn_i)
		send_valid_i && send_fsync_i |=> drop_cnt_q == 5'h01;
	endproperty
	a_align: assert property (p_align) else $error("frame alignment lost");

	property p_insert;
		@(posedge clk_i) disable iff (!rstn_i)
		ins_hit |=> take_q && (rd_q == $past(agg_rx_data_i));
	endproperty
	a_insert: assert property (p_insert) else $error("aggregate byte not inserted");

	property p_ins_pass;
		@(posedge clk_i) disable iff (!rstn_i)
		ins_valid && !ins_hit |=> !take_q && (rd_q == $past(ins_byte));
	endproperty
	a_ins_pass: assert property (p_ins_pass) else $error("unselected slot altered");

	property p_single;
		@(posedge clk_i) disable iff (!rstn_i)
		!twin_mode_i && send_valid_i ##1 !twin_mode_i |=> receive_valid_o;
	endproperty
	a_single: assert property (p_single) else $error("single bearer path broken");

endmodule

// ### dv/tdm_bearer_src.sv
// bearer line equipment model: framed byte stream source
`timescale 1ns/1ns
module tdm_bearer_src (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic e1_i,
	output logic [7:0] data_o,
	output logic valid_o,
	output logic fsync_o
);
	logic [4:0] idx_q;
	initial begin
		data_o = 8'h00;
		valid_o = 1'b0;
		fsync_o = 1'b0;
		idx_q = 5'h00;
	end
	// idle cycles show a changing byte so stale data never looks valid
	always @(negedge clk_i) begin
		data_o = ~data_o;
		valid_o = 1'b0;
		fsync_o = 1'b0;
		if (!rstn_i) begin
			idx_q = 5'h00;
		end else if ($urandom % 4 != 0) begin
			valid_o = 1'b1;
			data_o = 8'($urandom);
			fsync_o = idx_q == 5'h00;
			idx_q = (idx_q == (e1_i ? 5'h1f : 5'h17)) ? 5'h00 : idx_q + 5'h01;
		end
	end
	// reset is also sampled on the rising edge: a one-cycle pulse set on a falling edge
	// races the block above, and a missed pulse would start the next frame without a sync
	always @(posedge clk_i) begin
		if (!rstn_i) begin
			idx_q = 5'h00;
		end
	end
endmodule

// ### dv/tdm_mux_tb.sv
// self-checking bench for the timeslot drop and insert multiplexer
`timescale 1ns/1ns
module tdm_mux_tb;
	import tdm_pkg::*;
	logic clk_i = 0, rstn_i = 0, e1 = 0, t1e1 = 0, fill = 0, twin = 0;
	logic [31:0] dsel = 32'h00000000, isel = 32'h00000000;
	logic [7:0] sd, dd, ad, id, rd, rxd, e_dd, e_ad, e_rd, idm;
	logic sv, sf, dv, df, av, iv, ifs, take, rv, rf;
	logic e_dv, e_df, e_av, e_rv, e_rf, e_tk, ivm, ifm;
	int dslot = 0, islot = 0, ridx = 0, err_total = 0, checks = 0, cyc = 0;
	function automatic logic sel(input logic [31:0] m, input int s);
		int n = e1 ? s : s + 1;
		if (e1 && t1e1)
			return n >= 1 && n <= 25;
		return n != 0 && m[n];
	endfunction
	function automatic logic [7:0] agg(input int i);
		return 8'(i * 59 + 17);
	endfunction
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic final_report;
		if (err_total == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	assign rxd = agg(ridx);
	initial forever #5 clk_i = ~clk_i;
	tdm_bearer_src b1 (.clk_i(clk_i), .rstn_i(rstn_i), .e1_i(e1), .data_o(sd), .valid_o(sv), .fsync_o(sf));
	tdm_bearer_src b2 (.clk_i(clk_i), .rstn_i(rstn_i), .e1_i(e1), .data_o(id), .valid_o(iv), .fsync_o(ifs));
	tdm_mux dut (.clk_i(clk_i), .rstn_i(rstn_i), .e1_mode_i(e1), .t1_in_e1_i(t1e1), .idle_fill_i(fill),
		.twin_mode_i(twin), .drop_sel_i(dsel), .ins_sel_i(isel), .send_data_port_i(sd), .send_valid_i(sv),
		.send_fsync_i(sf), .dropped_data_out_port_o(dd), .dropped_valid_o(dv), .dropped_fsync_o(df),
		.agg_tx_data_o(ad), .agg_tx_valid_o(av), .insert_data_in_port_i(id), .insert_valid_i(iv),
		.insert_fsync_i(ifs), .agg_rx_data_i(rxd), .agg_rx_take_o(take), .receive_data_o(rd),
		.receive_valid_o(rv), .receive_fsync_o(rf));
	// ****************
	// reference model
	// ****************
	// single bearer feeds the insert side from last cycle's expected drop output
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			final_report;
		end
		ivm = twin ? iv : e_dv;
		idm = twin ? id : e_dd;
		ifm = twin ? ifs : e_df;
		if (!rstn_i) begin
			{e_dv, e_df, e_av, e_rv, e_rf, e_tk} = 6'h00;
			dslot = 0;
			islot = 0;
		end else begin
			e_dv = sv;
			e_df = sf;
			e_av = 1'b0;
			if (sv) begin
				dslot = sf ? 0 : (dslot + 1) % (e1 ? 32 : 24);
				e_av = sel(dsel, dslot);
				e_ad = sd;
				e_dd = (e_av && fill) ? (e1 ? TDM_IDLE_E1 : TDM_IDLE_T1) : sd;
			end
			e_rv = ivm;
			e_rf = ifm;
			e_tk = 1'b0;
			if (ivm) begin
				islot = ifm ? 0 : (islot + 1) % (e1 ? 32 : 24);
				e_tk = sel(isel, islot);
				e_rd = e_tk ? rxd : idm;
				if (e_tk)
					ridx <= ridx + 1;
			end
		end
	end
	always @(negedge clk_i) if (cyc > 0) begin
		chk(dv, e_dv);
		chk(av, e_av);
		chk(rv, e_rv);
		chk(take, e_tk);
		if (e_dv) begin
			chk(dd, e_dd);
			chk(df, e_df);
		end
		if (e_av)
			chk(ad, e_ad);
		if (e_rv) begin
			chk(rd, e_rd);
			chk(rf, e_rf);
		end
	end
	initial begin
		void'($urandom(53));
		repeat (8) @(negedge clk_i);
		for (int c = 0; c < 10; c++) begin
			// every case enables drop or insert, so the framer is taken to sit in ibs framing
			@(negedge clk_i);
			rstn_i = 1'b0;
			e1 = c[0];
			fill = c[1];
			twin = c[2];
			t1e1 = c == 9;
			dsel = c == 0 ? 32'hffffffff : c == 1 ? 32'haaaaaaaa : c == 3 ? 32'h00000000 : $urandom;
			isel = c == 0 ? 32'hffffffff : c == 1 ? 32'h55555555 : $urandom;
			@(negedge clk_i);
			rstn_i = 1'b1;
			repeat (100) @(negedge clk_i);
		end
		final_report;
	end
endmodule
